// >>> bench/i2c_local_ctrl_model.sv
// Local I2C controller model issuing address phases to the remap slice
`timescale 1ns/100ps
`default_nettype none
module i2c_local_ctrl_model
    import i2c_alias_remap_pkg::*;
(
    input  wire logic       clk_i,  // System clock
    input  wire logic       go_i,   // Issue one address phase
    input  wire logic [6:0] addr_i, // Address to send
    input  wire logic       rnw_i,  // Direction bit
    output i2c_req_type     req_o   // Address phase to the block
);
    // One pulse per phase; idle address parks at zero, which no alias decodes
    always @(posedge clk_i) begin
        req_o.valid <= go_i;
        req_o.rnw   <= rnw_i;
        req_o.addr  <= go_i ? addr_i : 7'h00;
    end
endmodule // i2c_local_ctrl_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench of the alias remap slice
`timescale 1ns/100ps
`default_nettype none
module tb;
    import i2c_alias_remap_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0, rnw = 0;
    logic [7:0]  adr_i = '0, lf = 8'h40;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0, dat_o;
    logic        ack_o, miss_o;
    logic [6:0]  addr = '0, ph0 = 7'h11, ph1 = 7'h62, al0 = '0, al1 = '0, f5, f6, f7;
    logic [7:0]  pv [3];
    i2c_req_type req;
    i2c_fwd_type fwd_o;
    logic [33:0] q [$];
    int          miscompares = 0, n_compared = 0, cycles = 0;

    i2c_local_ctrl_model ctrl (.clk_i(clk_i), .go_i(go), .addr_i(addr), .rnw_i(rnw), .req_o(req));
    i2c_alias_address_remap dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .phys_addr_0_i(ph0), .phys_addr_1_i(ph1), .target_phys_addr_field_5_o(f5),
        .target_phys_addr_field_6_o(f6), .target_phys_addr_field_7_o(f7),
        .req_i(req), .fwd_o(fwd_o), .miss_o(miss_o));

    initial forever #4 clk_i = ~clk_i;

    function automatic logic [7:0] nxt_lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
        cmp({2'd3, g}, {2'd3, e});
    endtask
    task automatic take(input logic [33:0] g);
        cmp(g, (q.size() > 0) ? q.pop_front() : ~g);
    endtask

    // Classic single cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        q.push_back({2'd0, 24'h0, e});
        wb(1'b0, idx, lf, 4'h1);
    endtask

    // Expected outcome follows the alias table held here
    task automatic send(input logic [6:0] a, input logic r);
        @(posedge clk_i);
        go   <= 1'b1;
        addr <= a;
        rnw  <= r;
        if (a != 7'h00 && a == al0) q.push_back({2'd1, 23'h0, 1'b0, r, ph0});
        else if (a != 7'h00 && a == al1) q.push_back({2'd1, 23'h0, 1'b1, r, ph1});
        else q.push_back({2'd2, 32'h0});
    endtask
    task automatic idle();
        @(posedge clk_i);
        go <= 1'b0;
    endtask

    // Outputs settle by the falling edge; a write ack also carries the register byte, but is not checked
    always @(negedge clk_i) if (!rst_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0) take({2'd0, dat_o});
        if (fwd_o.valid === 1'b1) take({2'd1, 23'h0, fwd_o.entry, fwd_o.rnw, fwd_o.addr});
        if (miss_o === 1'b1) take({2'd2, 32'h0});
    end

    task automatic close_out();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the hundred or so cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 13; i <= 17; i++) rd(6'(i), 8'h00);
        for (int i = 0; i < 3; i++) begin
            lf = nxt_lfsr(lf);
            pv[i] = lf;
            wb(1'b1, 6'(i + 13), lf, 4'h1);
            rd(6'(i + 13), lf);
        end
        chk_val({11'h0, f5, f6, f7}, {11'h0, pv[0][7:1], pv[1][7:1], pv[2][7:1]});
        wb(1'b1, 6'h0d, ~pv[0], 4'h0);
        rd(6'h0d, pv[0]);
        wb(1'b1, 6'h20, 8'hff, 4'h1);
        rd(6'h20, 8'h00);
        send(7'h00, 1'b0);
        send(lf[6:0], 1'b1);
        idle();
        al0 = lf[7:1] | 7'h01;
        al1 = al0 ^ 7'h55;
        wb(1'b1, 6'h10, {al0, 1'b1}, 4'h1);
        rd(6'h10, {al0, 1'b0});
        wb(1'b1, 6'h11, {al1, 1'b1}, 4'h1);
        rd(6'h11, {al1, 1'b0});
        send(al0, 1'b0);
        send(al1, 1'b1);
        send(al0 ^ 7'h01, 1'b0);
        for (int i = 0; i < 16; i++) begin
            lf = nxt_lfsr(lf);
            send(lf[1] ? (lf[0] ? al0 : al1) : lf[7:1], lf[2]);
        end
        idle();
        al1 = al0;
        wb(1'b1, 6'h11, {al1, 1'b0}, 4'h1);
        // New physical addresses while no request is in flight
        ph0 <= lf[6:0];
        ph1 <= ~lf[6:0];
        send(al0, 1'b1);
        idle();
        al0 = 7'h00;
        wb(1'b1, 6'h10, 8'h00, 4'h1);
        send(al1, 1'b0);
        send(7'h00, 1'b1);
        idle();
        repeat (4) @(posedge clk_i);
        chk_val(32'(q.size()), 32'h0);
        close_out();
    end
endmodule // tb
`default_nettype wire

// >>> hdl/i2c_alias_address_remap.sv
// Alias-to-physical I2C address translation slice with Wishbone registers
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_alias_remap_map.svh"

// Summary of operation
// - Each physical target register holds a 7-bit remote target address in bits 7 to 1.
// - A transaction addressed to alias N has its address replaced by physical address N, or by physical address 0 if both aliases match.
// - Every transaction that matched an alias is forwarded to the control channel.
// - Each alias register programs a decoder for local transactions meant for remote targets.
// - An alias of zero decodes nothing, so its remote target cannot be reached.
// - Alias entry N pairs with physical entry N as the source of the substitute address.
// - All alias and physical registers reset to zero, so both alias entries start disabled.
module i2c_alias_address_remap
    import i2c_alias_remap_pkg::*;
(
    input  wire logic        clk_i,              // 125 MHz system clock
    input  wire logic        rst_i,              // Synchronous reset, active high
    // Wishbone classic slave
    input  wire logic        cyc_i,              // Bus cycle
    input  wire logic        stb_i,              // Strobe
    input  wire logic        we_i,               // Write enable
    input  wire logic [7:0]  adr_i,              // Byte address
    input  wire logic [3:0]  sel_i,              // Byte lanes
    input  wire logic [31:0] dat_i,              // Write data
    output logic      [31:0] dat_o,              // Read data
    output logic             ack_o,              // Acknowledge
    // Physical addresses of entries 0 and 1, held in the neighbouring slice
    input  wire logic [6:0]  phys_addr_0_i,      // Physical address entry 0
    input  wire logic [6:0]  phys_addr_1_i,      // Physical address entry 1
    // Physical entries 5 to 7 handed to the neighbouring matchers
    output logic      [6:0]  target_phys_addr_field_5_o, // Physical address entry 5
    output logic      [6:0]  target_phys_addr_field_6_o, // Physical address entry 6
    output logic      [6:0]  target_phys_addr_field_7_o, // Physical address entry 7
    // Local I2C address phase in, forwarded phase out
    input  wire i2c_req_type req_i,              // Address phase from local engine
    output i2c_fwd_type      fwd_o,              // Translated phase to control channel
    output logic             miss_o              // Pulse: no alias matched
);

    // Nonzero alias equal to the incoming address
    function automatic logic alias_hit(input logic [6:0] alias_v, input logic [6:0] addr_v);
        alias_hit = (alias_v != `ALIAS_DISABLED) && (alias_v == addr_v);
    endfunction

    // Register index of the current bus address
    function automatic logic [5:0] reg_index(input logic [7:0] adr_v);
        reg_index = adr_v[7:2];
    endfunction

    logic [7:0]  phys_ff [3];      // Entries 5..7, bit 0 is plain storage
    logic [6:0]  alias_ff [2];     // Entries 0..1
    logic [6:0]  nxt_alias [2];
    logic [7:0]  nxt_phys [3];
    logic        ack_ff;
    logic [31:0] dat_ff;
    i2c_fwd_type fwd_ff;
    logic        miss_ff;

    // Bus decode
    wire logic       bus_req    = cyc_i & stb_i & ~ack_ff;
    // Write lands on the edge that samples ack, while the master still holds it
    wire logic       bus_wr     = cyc_i & stb_i & ack_ff & we_i & sel_i[0];
    wire logic [5:0] idx        = reg_index(adr_i);
    wire logic       sel_phys5  = (idx == `IDX_REMOTE_TARGET_ADDR_5);
    wire logic       sel_phys6  = (idx == `IDX_REMOTE_TARGET_ADDR_6);
    wire logic       sel_phys7  = (idx == `IDX_REMOTE_TARGET_ADDR_7);
    wire logic       sel_alias0 = (idx == `IDX_ALIAS_MATCH_ADDR_0);
    wire logic       sel_alias1 = (idx == `IDX_ALIAS_MATCH_ADDR_1);
    wire logic [2:0] sel_phys   = {sel_phys7, sel_phys6, sel_phys5};
    wire logic [1:0] sel_alias  = {sel_alias1, sel_alias0};

    // Read mux; unmapped addresses read as zero
    wire logic [7:0] rd_byte =
        sel_phys5  ? phys_ff[0] :
        sel_phys6  ? phys_ff[1] :
        sel_phys7  ? phys_ff[2] :
        sel_alias0 ? {alias_ff[0], 1'b0} :
        sel_alias1 ? {alias_ff[1], 1'b0} : 8'h00;

    genvar gp;
    generate
        for (gp = 0; gp < 3; gp++) begin : g_phys
            assign nxt_phys[gp] = (bus_wr && sel_phys[gp]) ? dat_i[7:0] : phys_ff[gp];
            always_ff @(posedge clk_i) begin
                if (rst_i) phys_ff[gp] <= `RST_TARGET_ADDR;
                else       phys_ff[gp] <= nxt_phys[gp];
            end
        end
    endgenerate

    // alias decoder programming; bit 0 is read-only zero
    genvar ga;
    generate
        for (ga = 0; ga < 2; ga++) begin : g_alias
            assign nxt_alias[ga] = (bus_wr && sel_alias[ga]) ?
                                   dat_i[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB] : alias_ff[ga];
            always_ff @(posedge clk_i) begin
                if (rst_i) alias_ff[ga] <= `RST_ALIAS_ADDR;
                else       alias_ff[ga] <= nxt_alias[ga];
            end
        end
    endgenerate

    // Wishbone answer: ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    wire logic hit0 = alias_hit(alias_ff[0], req_i.addr);
    wire logic hit1 = alias_hit(alias_ff[1], req_i.addr);
    wire logic any_hit = hit0 | hit1;

    // entry 0 wins when both aliases hold the same address
    wire logic [6:0] sub_addr = hit0 ? phys_addr_0_i : phys_addr_1_i;

    // Translation stage; registered so the channel sees a clean pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_ff  <= '0;
            miss_ff <= 1'b0;
        end else begin
            fwd_ff.valid <= req_i.valid & any_hit;
            // Address parks at zero between pulses so no stale address leaks out; rnw and entry still update every cycle
            fwd_ff.addr  <= (req_i.valid & any_hit) ? sub_addr : 7'h00;
            fwd_ff.rnw   <= req_i.rnw;
            fwd_ff.entry <= ~hit0;
            miss_ff      <= req_i.valid & ~any_hit;
        end
    end

    assign dat_o                      = dat_ff;
    assign ack_o                      = ack_ff;
    assign fwd_o                      = fwd_ff;
    assign miss_o                     = miss_ff;
    assign target_phys_addr_field_5_o = phys_ff[0][`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
    assign target_phys_addr_field_6_o = phys_ff[1][`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
    assign target_phys_addr_field_7_o = phys_ff[2][`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];

    // Checks on the translation path
    sequence s_hit0;
        req_i.valid && hit0;
    endsequence

    sequence s_hit1_only;
        req_i.valid && hit1 && !hit0;
    endsequence

    property p_fwd_entry0;
        @(posedge clk_i) disable iff (rst_i)
        s_hit0 |=> fwd_o.valid && fwd_o.addr == $past(phys_addr_0_i) && !fwd_o.entry;
    endproperty
    a_fwd_entry0: assert property (p_fwd_entry0)
        else $error("alias 0 hit not forwarded with physical address 0");

    property p_fwd_entry1;
        @(posedge clk_i) disable iff (rst_i)
        s_hit1_only |=> fwd_o.valid && fwd_o.addr == $past(phys_addr_1_i) && fwd_o.entry;
    endproperty
    a_fwd_entry1: assert property (p_fwd_entry1)
        else $error("alias 1 hit not paired with physical address 1");

    property p_fwd_rnw;
        @(posedge clk_i) disable iff (rst_i)
        req_i.valid && any_hit |=> fwd_o.valid && fwd_o.rnw == $past(req_i.rnw) && !miss_o;
    endproperty
    a_fwd_rnw: assert property (p_fwd_rnw)
        else $error("matched transaction not forwarded intact");

    property p_miss;
        @(posedge clk_i) disable iff (rst_i)
        req_i.valid && !any_hit |=> !fwd_o.valid && miss_o;
    endproperty
    a_miss: assert property (p_miss)
        else $error("unmatched address was forwarded");

    property p_zero_alias;
        @(posedge clk_i) disable iff (rst_i)
        req_i.valid && alias_ff[0] == 7'h00 && alias_ff[1] == 7'h00 |=> !fwd_o.valid;
    endproperty
    a_zero_alias: assert property (p_zero_alias)
        else $error("forward with all aliases disabled");

    property p_idle;
        @(posedge clk_i) disable iff (rst_i)
        !req_i.valid |=> !fwd_o.valid && !miss_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("forward pulse without a request");

    // Checks on the register file
    property p_reset_zero;
        @(posedge clk_i)
        $past(rst_i) |-> alias_ff[0] == 7'h00 && alias_ff[1] == 7'h00 &&
                         phys_ff[0] == 8'h00 && phys_ff[1] == 8'h00 && phys_ff[2] == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not zero after reset");

    property p_phys_write;
        @(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_phys6 |=> target_phys_addr_field_6_o == $past(dat_i[7:1]);
    endproperty
    a_phys_write: assert property (p_phys_write)
        else $error("physical entry 6 did not take write data");

    property p_alias_write;
        @(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_alias1 |=> alias_ff[1] == $past(dat_i[7:1]);
    endproperty
    a_alias_write: assert property (p_alias_write)
        else $error("alias entry 1 did not take write data");

    sequence s_bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> ack_o ##1 !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack not a single cycle answer");

    property p_alias_bit0;
        @(posedge clk_i) disable iff (rst_i)
        s_bus_req ##0 (sel_alias0 || sel_alias1) |=> dat_o[0] == 1'b0 && dat_o[31:8] == 24'h0;
    endproperty
    a_alias_bit0: assert property (p_alias_bit0)
        else $error("alias read shows reserved bit set");

    // Register file holds its value unless the matching slot is written
    property p_phys5_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(bus_wr && sel_phys5) |=> $stable(target_phys_addr_field_5_o);
    endproperty
    a_phys5_hold: assert property (p_phys5_hold)
        else $error("physical entry 5 changed without a write");

    property p_phys7_write;
        @(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_phys7 |=> target_phys_addr_field_7_o == $past(dat_i[7:1]);
    endproperty
    a_phys7_write: assert property (p_phys7_write)
        else $error("physical entry 7 did not take write data");

    property p_alias0_write;
        @(posedge clk_i) disable iff (rst_i)
        bus_wr && sel_alias0 |=> alias_ff[0] == $past(dat_i[7:1]);
    endproperty
    a_alias0_write: assert property (p_alias0_write)
        else $error("alias entry 0 did not take write data");

    property p_alias0_hold;
        @(posedge clk_i) disable iff (rst_i)
        !(bus_wr && sel_alias0) |=> $stable(alias_ff[0]);
    endproperty
    a_alias0_hold: assert property (p_alias0_hold)
        else $error("alias entry 0 changed without a write");

    // A write with lane 0 off must not disturb physical entry 5 or alias entry 1
    property p_lane_off;
        @(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && we_i && !sel_i[0] |=> $stable(phys_ff[0]) && $stable(alias_ff[1]);
    endproperty
    a_lane_off: assert property (p_lane_off)
        else $error("write with lane 0 off changed a register");

    // Read of entry 7 returns the stored byte in the answer cycle
    property p_read_phys7;
        @(posedge clk_i) disable iff (rst_i)
        s_bus_req ##0 (!we_i && sel_phys7) |=> dat_o == {24'h00_0000, $past(phys_ff[2])};
    endproperty
    a_read_phys7: assert property (p_read_phys7)
        else $error("read of physical entry 7 returned wrong data");

    // No answer without a bus request; a stray ack would confuse the master
    property p_ack_idle;
        @(posedge clk_i) disable iff (rst_i)
        !(cyc_i && stb_i) |=> !ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("ack without a bus request");

    // Between pulses the channel sees a zero address
    property p_fwd_addr_idle;
        @(posedge clk_i) disable iff (rst_i)
        !fwd_o.valid |-> fwd_o.addr == 7'h00;
    endproperty
    a_fwd_addr_idle: assert property (p_fwd_addr_idle)
        else $error("forward address not parked at zero");

    // Outputs quiet right after reset
    property p_reset_out;
        @(posedge clk_i)
        $past(rst_i) |-> !ack_o && !fwd_o.valid && !miss_o && dat_o == 32'h0000_0000;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not quiet after reset");

endmodule // i2c_alias_address_remap
`default_nettype wire

// >>> hdl/i2c_alias_remap_map.svh
// Register offsets, field positions and reset values of the alias remap slice
`ifndef I2C_ALIAS_REMAP_MAP_SVH
`define I2C_ALIAS_REMAP_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_REMOTE_TARGET_ADDR_5 6'h0d
`define IDX_REMOTE_TARGET_ADDR_6 6'h0e
`define IDX_REMOTE_TARGET_ADDR_7 6'h0f
`define IDX_ALIAS_MATCH_ADDR_0   6'h10
`define IDX_ALIAS_MATCH_ADDR_1   6'h11

// Field layout: 7-bit address in bits 7..1
`define ADDR_FIELD_MSB 7
`define ADDR_FIELD_LSB 1
`define ADDR_WIDTH     7

// Reset values
`define RST_TARGET_ADDR 8'h00
`define RST_ALIAS_ADDR  7'h00
`define ALIAS_DISABLED  7'h00

// Wishbone word size
`define WB_DATA_W 32

`endif

// >>> hdl/i2c_alias_remap_pkg.sv
// Types shared by the alias remap slice
package i2c_alias_remap_pkg;

    // Address phase seen by the local I2C engine
    typedef struct packed {
        logic       valid;  // One-cycle pulse per address phase
        logic [6:0] addr;   // 7-bit address from the local bus
        logic       rnw;    // Direction bit of the address byte
    } i2c_req_type;

    // Translated address phase handed to the control channel
    typedef struct packed {
        logic       valid;  // One-cycle pulse, forward this transaction
        logic [6:0] addr;   // Substituted physical address
        logic       rnw;    // Direction carried through
        logic       entry;  // Matching alias entry, 0 or 1
    } i2c_fwd_type;

endpackage
